// File: rtl/pit_ctrl_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "pit_regs.svh"

// ****************************************************************
// Control transfer into the RTC tick domain
// ****************************************************************
module pit_ctrl_sync (
    input  wire logic              clock,   // System clock
    input  wire logic              srst,    // Sync reset
    input  wire logic              load,    // Control written
    input  wire pit_pkg::pit_ctrl_t newCtrl, // Written value
    input  wire logic              rtcTick, // RTC tick
    output pit_pkg::pit_ctrl_t     rtcCtrl, // Control in effect
    output logic                   busy,    // Transfer pending
    output logic                   done     // One-cycle completion
);
    import pit_pkg::*;

    pit_sync_state_t state_q;
    pit_sync_state_t state_d;
    pit_ctrl_t       hold_q;
    pit_ctrl_t       hold_d;
    pit_ctrl_t       act_q;
    pit_ctrl_t       act_d;
    logic            done_d;

    // A new write restarts the transfer with the latest value
    always_comb
    begin
        state_d = state_q;
        hold_d  = hold_q;
        act_d   = act_q;
        done_d  = 1'b0;
        if (load)
        begin
            state_d = SYNC_FIRST;
            hold_d  = newCtrl;
        end
        else if (rtcTick)
        begin
            unique case (state_q)
                SYNC_IDLE:   state_d = SYNC_IDLE;
                SYNC_FIRST:  state_d = SYNC_SECOND;
                SYNC_SECOND:
                begin
                    state_d = SYNC_IDLE;
                    act_d   = hold_q;
                    done_d  = 1'b1;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= SYNC_IDLE;
            hold_q  <= '0;
            act_q   <= '0;
            done    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            hold_q  <= hold_d;
            act_q   <= act_d;
            done    <= done_d;
        end
    end

    assign rtcCtrl = act_q;
    assign busy    = (state_q != SYNC_IDLE);
endmodule
`default_nettype wire

// File: rtl/pit_pkg.sv
package pit_pkg;

    // Control register contents as seen by the counter
    typedef struct packed {
        logic [3:0] period;
        logic       timerOn;
    } pit_ctrl_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pit_bus_req_t;

    // Control transfer into the RTC tick domain
    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_FIRST,
        SYNC_SECOND
    } pit_sync_state_t;

endpackage

// File: rtl/pit_regs.svh
`ifndef PIT_REGS_SVH
`define PIT_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PIT_OFS_CONTROL      8'h10
`define PIT_OFS_SYNC_STATUS  8'h11
`define PIT_OFS_IRQ_ENABLE   8'h12
`define PIT_OFS_IRQ_FLAG     8'h13
`define PIT_OFS_DEBUG_CTRL   8'h15
`define PIT_OFS_EVT_STATUS   8'h16
`define PIT_OFS_EVT_MASK     8'h17
`define PIT_OFS_CLOCK_SOURCE 8'h18

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PIT_BIT_TIMER_ON     0
`define PIT_BIT_PERIOD_LO    3
`define PIT_BIT_PERIOD_HI    6
`define PIT_BIT_SYNC_PEND    0
`define PIT_BIT_PERIODIC_IRQ 0
`define PIT_BIT_RUN_HALTED   0
`define PIT_BIT_EVT_PERIODIC 0
`define PIT_BIT_EVT_SYNCDONE 1
`define PIT_RST_BYTE         8'h00
`define PIT_PERIOD_OFF       4'h0
`define PIT_PERIOD_RESERVED  4'hf

// ****************************************************************
// Clock source codes
// ****************************************************************
`define PIT_SRC_ULP32K       2'h0
`define PIT_SRC_ULP1K        2'h1
`define PIT_SRC_XTAL         2'h2
`define PIT_SRC_EXTPIN       2'h3

// ****************************************************************
// Timing: rates in Hz, divider counts in system cycles, sync count in RTC ticks
// ****************************************************************
`define PIT_SYS_HZ           20000000
`define PIT_ULP32_HZ         32768
`define PIT_ULP1_HZ          1024
`define PIT_ULP32_DIV        (`PIT_SYS_HZ / `PIT_ULP32_HZ)
`define PIT_ULP1_DIV         (`PIT_SYS_HZ / `PIT_ULP1_HZ)
`define PIT_SYNC_TICKS       2

`endif

// File: rtl/pit_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "pit_regs.svh"

// ****************************************************************
// RTC tick enable from the selected source
// ****************************************************************
module pit_tick_gen #(
    parameter int DIV32 = `PIT_ULP32_DIV,
    parameter int DIV1  = `PIT_ULP1_DIV
) (
    input  wire logic       clock,     // System clock
    input  wire logic       srst,      // Sync reset
    input  wire logic [1:0] source,    // Selected source
    input  wire logic       xtalClk,   // Crystal clock level
    input  wire logic       extClk,    // External clock pin level
    output logic            rtcTick    // One-cycle RTC tick
);
    import pit_pkg::*;

    logic [15:0] div_q;
    logic [15:0] div_d;
    logic        xtalPrev_q;
    logic        extPrev_q;
    logic        tick_q;
    logic        tick_d;
    logic [15:0] limit;

    // Divider limit and tick selection
    always_comb
    begin
        limit  = (source == `PIT_SRC_ULP1K) ? 16'(DIV1 - 1) : 16'(DIV32 - 1);
        div_d  = (div_q >= limit) ? 16'h0000 : div_q + 16'h0001;
        unique case (source)
            `PIT_SRC_ULP32K,
            `PIT_SRC_ULP1K:  tick_d = (div_q >= limit);
            `PIT_SRC_XTAL:   tick_d = xtalClk & ~xtalPrev_q;
            `PIT_SRC_EXTPIN: tick_d = extClk & ~extPrev_q;
        endcase
    end

    // Divider and edge registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            div_q      <= 16'h0000;
            xtalPrev_q <= 1'b0;
            extPrev_q  <= 1'b0;
            tick_q     <= 1'b0;
        end
        else
        begin
            div_q      <= div_d;
            xtalPrev_q <= xtalClk;
            extPrev_q  <= extClk;
            tick_q     <= tick_d;
        end
    end

    assign rtcTick = tick_q;
endmodule
`default_nettype wire

// File: rtl/pit_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pit_regs.svh"

module pit_timer #(
    parameter int ULP1_DIV = `PIT_ULP1_DIV
) (
    input  wire logic       clock,       // 20 MHz system clock
    input  wire logic       srst,        // Sync reset, active high
    input  wire logic [7:0] regAddr,     // Register address
    input  wire logic [7:0] regWdata,    // Write data
    input  wire logic       regWr,       // Write strobe
    input  wire logic       regRd,       // Read strobe
    output logic      [7:0] regRdata,    // Read data, cycle after strobe
    input  wire logic       cpuHalted,   // Processor in break debug
    input  wire logic       xtalClk,     // Crystal clock level
    input  wire logic       extClk,      // External clock pin level
    output logic            periodicIrq, // Periodic interrupt request
    output logic            irq          // Masked event interrupt
);
    import pit_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    pit_bus_req_t req;
    pit_ctrl_t    ctrl_q;
    pit_ctrl_t    ctrl_d;
    pit_ctrl_t    rtcCtrl;
    logic         irqEn_q;
    logic         irqEn_d;
    logic         flag_q;
    logic         flag_d;
    logic         runHalted_q;
    logic         runHalted_d;
    logic [1:0]   clkSrc_q;
    logic [1:0]   clkSrc_d;
    logic [1:0]   evtStat_q;
    logic [1:0]   evtStat_d;
    logic [1:0]   evtMask_q;
    logic [1:0]   evtMask_d;
    logic [14:0]  cnt_q;
    logic [14:0]  cnt_d;
    logic [7:0]   rdata_d;
    logic         pirq_d;
    logic         irq_d;
    logic         rtcTick;
    logic         ctrlLoad;
    logic         syncBusy;
    logic         syncDone;
    logic         counting;
    logic         periodEvt;

    // Last count of an interval: spacing is 2^(code+1) ticks
    function automatic logic [14:0] lastCount(input logic [3:0] code);
        logic [15:0] span;
        span      = 16'h0001 << (code + 4'h1);
        lastCount = 15'(span - 16'h0001);
    endfunction

    // Valid interval code
    function automatic logic periodValid(input logic [3:0] code);
        periodValid = (code != `PIT_PERIOD_OFF) && (code != `PIT_PERIOD_RESERVED);
    endfunction

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
    assign ctrlLoad = req.wr && (req.addr == `PIT_OFS_CONTROL);

    // ****************************************************************
    // Tick source and control transfer
    // ****************************************************************
    pit_tick_gen #(
        .DIV32 (`PIT_ULP32_DIV),
        .DIV1  (ULP1_DIV)
    ) u_tick (
        .clock   (clock),
        .srst    (srst),
        .source  (clkSrc_q),
        .xtalClk (xtalClk),
        .extClk  (extClk),
        .rtcTick (rtcTick)
    );

    pit_ctrl_sync u_sync (
        .clock   (clock),
        .srst    (srst),
        .load    (ctrlLoad),
        .newCtrl (ctrl_d),
        .rtcTick (rtcTick),
        .rtcCtrl (rtcCtrl),
        .busy    (syncBusy),
        .done    (syncDone)
    );

    // ****************************************************************
    // Interval counter
    // ****************************************************************
    // Counting gate and interval completion
    always_comb
    begin
        counting  = rtcCtrl.timerOn && periodValid(rtcCtrl.period);
        periodEvt = 1'b0;
        cnt_d     = cnt_q;
        if (!counting)
            cnt_d = 15'h0000;
        else if (rtcTick && (runHalted_q || !cpuHalted))
        begin
            if (cnt_q >= lastCount(rtcCtrl.period))
            begin
                cnt_d     = 15'h0000;
                periodEvt = 1'b1;
            end
            else
                cnt_d = cnt_q + 15'h0001;
        end
    end

    // ****************************************************************
    // Register writes and flags
    // ****************************************************************
    // Next register values, set beats clear
    always_comb
    begin
        ctrl_d      = ctrl_q;
        irqEn_d     = irqEn_q;
        runHalted_d = runHalted_q;
        clkSrc_d    = clkSrc_q;
        evtMask_d   = evtMask_q;
        flag_d      = flag_q;
        evtStat_d   = evtStat_q;
        if (req.wr)
        begin
            unique case (req.addr)
                `PIT_OFS_CONTROL:
                begin
                    ctrl_d.period  = req.wdata[`PIT_BIT_PERIOD_HI:`PIT_BIT_PERIOD_LO];
                    ctrl_d.timerOn = req.wdata[`PIT_BIT_TIMER_ON];
                end
                `PIT_OFS_IRQ_ENABLE:   irqEn_d     = req.wdata[`PIT_BIT_PERIODIC_IRQ];
                `PIT_OFS_DEBUG_CTRL:   runHalted_d = req.wdata[`PIT_BIT_RUN_HALTED];
                `PIT_OFS_CLOCK_SOURCE: clkSrc_d    = req.wdata[1:0];
                `PIT_OFS_EVT_MASK:     evtMask_d   = req.wdata[1:0];
                `PIT_OFS_IRQ_FLAG:
                    if (req.wdata[`PIT_BIT_PERIODIC_IRQ])
                        flag_d = 1'b0;
                default:               ctrl_d = ctrl_q;
            endcase
        end
        if (req.rd && (req.addr == `PIT_OFS_EVT_STATUS))
            evtStat_d = 2'h0;
        if (periodEvt)
        begin
            flag_d                          = 1'b1;
            evtStat_d[`PIT_BIT_EVT_PERIODIC] = 1'b1;
        end
        if (syncDone)
            evtStat_d[`PIT_BIT_EVT_SYNCDONE] = 1'b1;
    end

    // ****************************************************************
    // Read path and outputs
    // ****************************************************************
    // Read mux, reserved bits zero
    always_comb
    begin
        rdata_d = `PIT_RST_BYTE;
        if (req.rd)
        begin
            unique case (req.addr)
                `PIT_OFS_CONTROL:
                begin
                    rdata_d[`PIT_BIT_PERIOD_HI:`PIT_BIT_PERIOD_LO] = ctrl_q.period;
                    rdata_d[`PIT_BIT_TIMER_ON]                     = ctrl_q.timerOn;
                end
                `PIT_OFS_SYNC_STATUS:  rdata_d[`PIT_BIT_SYNC_PEND]    = syncBusy;
                `PIT_OFS_IRQ_ENABLE:   rdata_d[`PIT_BIT_PERIODIC_IRQ] = irqEn_q;
                `PIT_OFS_IRQ_FLAG:     rdata_d[`PIT_BIT_PERIODIC_IRQ] = flag_q;
                `PIT_OFS_DEBUG_CTRL:   rdata_d[`PIT_BIT_RUN_HALTED]   = runHalted_q;
                `PIT_OFS_CLOCK_SOURCE: rdata_d[1:0]                   = clkSrc_q;
                `PIT_OFS_EVT_STATUS:   rdata_d[1:0]                   = evtStat_q;
                `PIT_OFS_EVT_MASK:     rdata_d[1:0]                   = evtMask_q;
                default:               rdata_d = `PIT_RST_BYTE;
            endcase
        end
        pirq_d = flag_d && irqEn_d;
        irq_d  = |(evtStat_d & evtMask_d);
    end

    // State registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_q      <= '0;
            irqEn_q     <= 1'b0;
            flag_q      <= 1'b0;
            runHalted_q <= 1'b0;
            clkSrc_q    <= `PIT_SRC_ULP32K;
            evtStat_q   <= 2'h0;
            evtMask_q   <= 2'h0;
            cnt_q       <= 15'h0000;
            regRdata    <= `PIT_RST_BYTE;
            periodicIrq <= 1'b0;
            irq         <= 1'b0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            irqEn_q     <= irqEn_d;
            flag_q      <= flag_d;
            runHalted_q <= runHalted_d;
            clkSrc_q    <= clkSrc_d;
            evtStat_q   <= evtStat_d;
            evtMask_q   <= evtMask_d;
            cnt_q       <= cnt_d;
            regRdata    <= rdata_d;
            periodicIrq <= pirq_d;
            irq         <= irq_d;
        end
    end
endmodule
`default_nettype wire

// File: verification/pit_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench
// ********
module pit_timer_bench;
    localparam int DIV1  = 8;
    localparam int LIMIT = 60000;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic       cpuHalted = 1'b0;
    logic       xtalClk = 1'b0;
    logic       extClk = 1'b0;
    logic [7:0] regRdata;
    logic       periodicIrq;
    logic       irq;
    logic       hit;
    int         miscompares = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         seed = 69;
    int         t1;
    int         t2;

    pit_timer #(.ULP1_DIV(DIV1)) dut (
        .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuHalted(cpuHalted),
        .xtalClk(xtalClk), .extClk(extClk), .periodicIrq(periodicIrq), .irq(irq)
    );

    initial
    forever #25 clock = ~clock;

    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Pin clocks rise every 6 cycles; hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles % 3 == 0)
        begin
            extClk  <= ~extClk;
            xtalClk <= ~xtalClk;
        end
        if (cycles >= LIMIT)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        // Strobe still up from a previous write: let it drop for one edge first
        if (regWr)
            @(posedge clock);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        chk("read data", {24'h0, exp & m}, {24'h0, regRdata & m});
        @(posedge clock);
    endtask

    task automatic clear_flag;
        wr(8'h13, 8'h01);
        repeat (2) @(posedge clock);
    endtask

    // Waits for the request; hit tells if it came
    task automatic wait_irq(input int lim, output int t);
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (periodicIrq !== 1'b1 && n < lim);
        t = cycles;
        hit = periodicIrq;
        @(posedge clock);
    endtask

    task automatic interval(input logic [7:0] src, input logic [3:0] code, input int exp);
        wr(8'h18, src);
        wr(8'h10, {1'b0, code, 3'b001});
        wait_irq(3 * exp + 200, t1);
        clear_flag();
        wait_irq(3 * exp + 200, t1);
        clear_flag();
        wait_irq(3 * exp + 200, t2);
        chk("interval", exp, t2 - t1);
    endtask

    initial
    begin
        logic [7:0] d;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int a = 16; a <= 24; a++)
            rd(8'(a), 8'h00, 8'hff);
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($random(seed));
            wr(8'h10, d);
            rd(8'h10, d & 8'h79, 8'hff);
            wr(8'h12, d);
            rd(8'h12, d & 8'h01, 8'hff);
            wr(8'h15, d);
            rd(8'h15, d & 8'h01, 8'hff);
            wr(8'h11, d);
            rd(8'h11, 8'h00, 8'hfe);
            wr(8'h14, d);
            rd(8'h14, 8'h00, 8'hff);
            wr(8'h18, d);
            rd(8'h18, d & 8'h03, 8'hff);
        end
        // Busy during control transfer
        wr(8'h12, 8'h00);
        wr(8'h15, 8'h00);
        wr(8'h18, 8'h01);
        wr(8'h10, 8'h09);
        rd(8'h11, 8'h01, 8'hff);
        repeat (4 * DIV1) @(posedge clock);
        rd(8'h11, 8'h00, 8'hff);
        // Flag with request masked, then unmasked
        clear_flag();
        repeat (120) @(posedge clock);
        rd(8'h13, 8'h01, 8'hff);
        chk("request", 32'h0, {31'h0, periodicIrq});
        wr(8'h13, 8'h00);
        rd(8'h13, 8'h01, 8'hff);
        wr(8'h12, 8'h01);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("request", 32'h1, {31'h0, periodicIrq});
        @(posedge clock);
        clear_flag();
        // Align to a fresh event so no new one lands before the read
        wait_irq(200, t1);
        clear_flag();
        rd(8'h13, 8'h00, 8'hff);
        // Event interrupt raised, cleared by read, masked
        wr(8'h17, 8'h01);
        wait_irq(200, t1);
        @(negedge clock);
        chk("event irq", 32'h1, {31'h0, irq});
        @(posedge clock);
        rd(8'h16, 8'h01, 8'h01);
        @(negedge clock);
        chk("event irq", 32'h0, {31'h0, irq});
        @(posedge clock);
        wr(8'h17, 8'h00);
        // Spacing for codes and sources
        for (int c = 1; c <= 6; c++)
            interval(8'h01, 4'(c), (2 ** (c + 1)) * DIV1);
        interval(8'h00, 4'h1, 2440);
        interval(8'h02, 4'h1, 24);
        interval(8'h03, 4'h1, 24);
        // Off code, reserved code, timer off
        wr(8'h18, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? 8'h01 : (k == 1) ? 8'h79 : 8'h08;
            wr(8'h10, d);
            repeat (40) @(posedge clock);
            clear_flag();
            wait_irq(300, t1);
            chk("silent", 32'h0, {31'h0, hit});
        end
        // Halted without and with debug run
        wr(8'h10, 8'h09);
        cpuHalted <= 1'b1;
        repeat (40) @(posedge clock);
        clear_flag();
        wait_irq(300, t1);
        chk("halted", 32'h0, {31'h0, hit});
        wr(8'h15, 8'h01);
        wait_irq(300, t1);
        chk("halted run", 32'h1, {31'h0, hit});
        cpuHalted <= 1'b0;
        tally_and_finish();
    end
endmodule

bind pit_timer pit_timer_monitor mon (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuHalted(cpuHalted),
    .xtalClk(xtalClk), .extClk(extClk), .periodicIrq(periodicIrq), .irq(irq)
);

`default_nettype wire

// File: verification/pit_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Port checks
// ********
module pit_timer_monitor (
    input  wire logic       clock,       // Clock
    input  wire logic       srst,        // Reset
    input  wire logic [7:0] regAddr,     // Address
    input  wire logic [7:0] regWdata,    // Write data
    input  wire logic       regWr,       // Write
    input  wire logic       regRd,       // Read
    input  wire logic [7:0] regRdata,    // Read data
    input  wire logic       cpuHalted,   // Halt
    input  wire logic       xtalClk,     // Crystal
    input  wire logic       extClk,      // Pin clock
    input  wire logic       periodicIrq, // Request
    input  wire logic       irq          // Event irq
);
    logic clrReq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Writes that may drop the request
    assign clrReq = regWr && ((regAddr == 8'h13 && regWdata[0]) ||
                              (regAddr == 8'h12 && !regWdata[0]));

    AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside read");
    AST_UNMAPPED: assert property (regRd && regAddr inside {8'h14, [8'h19:8'hff],
        [8'h00:8'h0f]} |=> regRdata == 8'h00) else $error("unmapped read not zero");
    AST_BIT_RSVD: assert property (regRd && regAddr inside {8'h11, 8'h12, 8'h13,
        8'h15} |=> regRdata[7:1] == 7'h00) else $error("reserved bits set");
    AST_CTRL_RSVD: assert property (regRd && regAddr == 8'h10
        |=> (regRdata & 8'h86) == 8'h00) else $error("control reserved bits set");
    AST_CTRL_BACK: assert property ((regWr && regAddr == 8'h10) ##1
        (regRd && regAddr == 8'h10) |=> regRdata == ($past(regWdata, 2) & 8'h79))
        else $error("control readback wrong");
    AST_EN_BACK: assert property ((regWr && regAddr == 8'h12) ##1
        (regRd && regAddr == 8'h12) |=> regRdata == ($past(regWdata, 2) & 8'h01))
        else $error("enable readback wrong");
    AST_DBG_BACK: assert property ((regWr && regAddr == 8'h15) ##1
        (regRd && regAddr == 8'h15) |=> regRdata == ($past(regWdata, 2) & 8'h01))
        else $error("debug readback wrong");
    AST_BUSY: assert property ((regWr && regAddr == 8'h10) ##1
        (regRd && regAddr == 8'h11) |=> regRdata[0]) else $error("busy not shown");
    AST_IRQ_OFF: assert property (regWr && regAddr == 8'h12 && !regWdata[0]
        |-> ##2 !periodicIrq) else $error("request while disabled");
    AST_IRQ_FALL: assert property ($fell(periodicIrq) |-> $past(clrReq))
        else $error("request dropped without cause");
endmodule

`default_nettype wire
